/* File: logic/ipe_defs.svh */
`ifndef IPE_DEFS_SVH
`define IPE_DEFS_SVH

// Register indices; the bus byte address is four times the index.
`define IPE_IDX_PRIO_A  16'hFF10
`define IPE_IDX_PRIO_B  16'hFF11
`define IPE_IDX_PORT_EN 16'hFF14
`define IPE_IDX_TMR_EN  16'hFF15

`define IPE_RST_REG     8'h00
`define IPE_RESP_OKAY   2'h0
`define IPE_RESP_SLVERR 2'h2
`define IPE_LEVEL_NONE  2'h0

// Fields of priority_reg_a.
`define IPE_A_SERIAL0   7:6
`define IPE_A_TIMER10   5:4
`define IPE_A_TIMER32   3:2
`define IPE_A_PORT      1:0

// Fields of priority_reg_b.
`define IPE_B_TIMER54   7:6
`define IPE_B_TIMER76   5:4
`define IPE_B_CLOCK     3:2
`define IPE_B_SERIAL1   1:0

// Bits of timer_low_irq_enables.
`define IPE_T_MATCH0    0
`define IPE_T_MATCH1    3
`define IPE_T_MATCH2    5
`define IPE_T_MATCH3    7
`define IPE_T_UF0       1
`define IPE_T_UF1       2
`define IPE_T_UF2       4
`define IPE_T_UF3       6

`endif

/* File: logic/ipe_pkg.sv */
package ipe_pkg;

	typedef logic [1:0] ipe_level_t;

	typedef enum logic [2:0] {
		IPE_SEL_NONE,
		IPE_SEL_PRIO_A,
		IPE_SEL_PRIO_B,
		IPE_SEL_PORT_EN,
		IPE_SEL_TMR_EN
	} ipe_sel_e;

	typedef struct packed {
		logic [7:0] prio_a;
		logic [7:0] prio_b;
		logic [7:0] port_en;
		logic [7:0] tmr_en;
		logic       aw_hold;
		logic       w_hold;
		ipe_sel_e   wsel;
		logic [7:0] wdata;
		logic       wstrb0;
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} ipe_regs_s;

endpackage : ipe_pkg

/* File: logic/ipe_gate.sv */
`timescale 1ns/1ns
`include "ipe_defs.svh"
// Registers each request only when enabled and its level is not zero, with its level.
module ipe_gate #(
	parameter int N = 8
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [N-1:0]     req,
	input  wire logic [N-1:0]     en,
	input  wire logic [2*N-1:0]   level,
	output logic      [N-1:0]     irq,
	output logic      [2*N-1:0]   irq_level
);

	typedef struct packed {
		logic [N-1:0]   irq;
		logic [2*N-1:0] level;
	} ipe_gate_s;

	ipe_gate_s    s_q;
	ipe_gate_s    s_d;
	logic [N-1:0] pass;

	if (N < 1)
	begin : g_bad_n
		$error("ipe_gate needs at least one source.");
	end

	for (genvar i = 0; i < N; i++)
	begin : g_src
		assign pass[i] = req[i] & en[i] & (level[2*i +: 2] != `IPE_LEVEL_NONE); // RULE10
	end

	always_comb
	begin
		s_d       = s_q;
		s_d.irq   = pass;
		s_d.level = level;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign irq       = s_q.irq;
	assign irq_level = s_q.level;

endmodule : ipe_gate

/* File: logic/ipe_regs.sv */
`timescale 1ns/1ns
`include "ipe_defs.svh"

// Summary of operation
// RULE1: Serial 0 two-bit priority sits in priority_reg_a, read/write, reset zero.
// RULE2: One two-bit priority serves every interrupt of timers 1 and 0.
// RULE3: One two-bit priority serves timers 3 and 2, read/write, reset zero.
// RULE4: One two-bit priority governs all eight port interrupt inputs.
// RULE5: Timers 5-4 and 7-6 priorities sit in priority_reg_b, reset zero.
// RULE6: Clock timer priority sits in priority_reg_b, writable, cleared at reset.
// RULE7: Serial 1 has a priority field; codes 00, 01, 11 mean levels 0, 1, 3.
// RULE8: Each of timers 0-3 has a compare-match enable bit, one enables, reset zero.
// RULE9: Each of timers 0-3 has an underflow enable bit in the same register.
// RULE10: A request passes only when enabled, tagged with its level; level 0 blocks it.
// RULE11: Priority code 10 means level 2.
module ipe_regs #(
	parameter int ADDR_W = 18
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [7:0]        port_req,
	input  wire logic [3:0]        timer_match_req,
	input  wire logic [3:0]        timer_underflow_req,
	output logic [1:0]             serial0_level,
	output logic [1:0]             serial1_level,
	output logic [1:0]             timer10_level,
	output logic [1:0]             timer32_level,
	output logic [1:0]             timer54_level,
	output logic [1:0]             timer76_level,
	output logic [1:0]             clock_timer_level,
	output logic [1:0]             port_level,
	output logic [7:0]             port_irq,
	output logic [15:0]            port_irq_level,
	output logic [3:0]             timer_match_irq,
	output logic [3:0]             timer_underflow_irq,
	output logic [15:0]            timer_irq_level
);

	localparam ipe_pkg::ipe_regs_s RST = '0;

	ipe_pkg::ipe_regs_s  s_q;
	ipe_pkg::ipe_regs_s  s_d;
	logic                wr_fire;
	logic [3:0]          match_en;
	logic [3:0]          uf_en;
	ipe_pkg::ipe_level_t lvl10;
	ipe_pkg::ipe_level_t lvl32;
	logic [7:0]          tmr_lvl;

	if (ADDR_W < 18)
	begin : g_bad_addr
		$error("ipe_regs needs ADDR_W of at least 18 bits.");
	end

	function automatic ipe_pkg::ipe_sel_e sel_of(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] idx;
		idx = a[ADDR_W-1:2];
		if (idx == (ADDR_W-2)'(`IPE_IDX_PRIO_A))
			return ipe_pkg::IPE_SEL_PRIO_A;
		else if (idx == (ADDR_W-2)'(`IPE_IDX_PRIO_B))
			return ipe_pkg::IPE_SEL_PRIO_B;
		else if (idx == (ADDR_W-2)'(`IPE_IDX_PORT_EN))
			return ipe_pkg::IPE_SEL_PORT_EN;
		else if (idx == (ADDR_W-2)'(`IPE_IDX_TMR_EN))
			return ipe_pkg::IPE_SEL_TMR_EN;
		else
			return ipe_pkg::IPE_SEL_NONE;
	endfunction : sel_of

	function automatic logic [7:0] rd_of(input ipe_pkg::ipe_sel_e sel,
		input ipe_pkg::ipe_regs_s s);
		case (sel)
			ipe_pkg::IPE_SEL_PRIO_A:  return s.prio_a;
			ipe_pkg::IPE_SEL_PRIO_B:  return s.prio_b;
			ipe_pkg::IPE_SEL_PORT_EN: return s.port_en;
			ipe_pkg::IPE_SEL_TMR_EN:  return s.tmr_en;
			default:                  return 8'h00;
		endcase
	endfunction : rd_of

	// A write commits once both address and data are held and no response is pending.
	assign wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;

	always_comb
	begin
		s_d = s_q;
		if (s_q.bvalid && bready)
			s_d.bvalid = 1'b0;
		if (s_q.rvalid && rready)
			s_d.rvalid = 1'b0;
		if (awvalid && s_q.awready)
		begin
			s_d.aw_hold = 1'b1;
			s_d.wsel    = sel_of(awaddr);
		end
		if (wvalid && s_q.wready)
		begin
			s_d.w_hold = 1'b1;
			s_d.wdata  = wdata[7:0];
			s_d.wstrb0 = wstrb[0];
		end
		if (wr_fire)
		begin
			s_d.aw_hold = 1'b0;
			s_d.w_hold  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = `IPE_RESP_OKAY;
			case (s_q.wsel)
				ipe_pkg::IPE_SEL_PRIO_A:
				begin
					if (s_q.wstrb0)
						s_d.prio_a = s_q.wdata; // RULE1 RULE2 RULE3 RULE4
				end
				ipe_pkg::IPE_SEL_PRIO_B:
				begin
					if (s_q.wstrb0)
						s_d.prio_b = s_q.wdata; // RULE5 RULE6 RULE7
				end
				ipe_pkg::IPE_SEL_PORT_EN:
				begin
					if (s_q.wstrb0)
						s_d.port_en = s_q.wdata;
				end
				ipe_pkg::IPE_SEL_TMR_EN:
				begin
					if (s_q.wstrb0)
						s_d.tmr_en = s_q.wdata; // RULE8 RULE9
				end
				default:
					s_d.bresp = `IPE_RESP_SLVERR;
			endcase
		end
		if (arvalid && s_q.arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd_of(sel_of(araddr), s_q);
			if (sel_of(araddr) == ipe_pkg::IPE_SEL_NONE)
				s_d.rresp = `IPE_RESP_SLVERR;
			else
				s_d.rresp = `IPE_RESP_OKAY;
		end
		s_d.awready = !s_d.aw_hold && !s_d.bvalid;
		s_d.wready  = !s_d.w_hold && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= RST; // RULE1 RULE3 RULE5 RULE6 RULE8
		else
			s_q <= s_d;
	end

	assign awready = s_q.awready;
	assign wready  = s_q.wready;
	assign bvalid  = s_q.bvalid;
	assign bresp   = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid  = s_q.rvalid;
	assign rresp   = s_q.rresp;
	assign rdata   = {24'h000000, s_q.rdata};

	// Each field is a level code as is: 00, 01, 10 and 11 are levels 0 to 3.
	assign serial0_level     = s_q.prio_a[`IPE_A_SERIAL0]; // RULE1
	assign timer10_level     = s_q.prio_a[`IPE_A_TIMER10]; // RULE2
	assign timer32_level     = s_q.prio_a[`IPE_A_TIMER32]; // RULE3
	assign port_level        = s_q.prio_a[`IPE_A_PORT]; // RULE4
	assign timer54_level     = s_q.prio_b[`IPE_B_TIMER54]; // RULE5
	assign timer76_level     = s_q.prio_b[`IPE_B_TIMER76]; // RULE5
	assign clock_timer_level = s_q.prio_b[`IPE_B_CLOCK]; // RULE6
	assign serial1_level     = s_q.prio_b[`IPE_B_SERIAL1]; // RULE7 RULE11

	assign match_en = {s_q.tmr_en[`IPE_T_MATCH3], s_q.tmr_en[`IPE_T_MATCH2],
		s_q.tmr_en[`IPE_T_MATCH1], s_q.tmr_en[`IPE_T_MATCH0]}; // RULE8
	assign uf_en    = {s_q.tmr_en[`IPE_T_UF3], s_q.tmr_en[`IPE_T_UF2],
		s_q.tmr_en[`IPE_T_UF1], s_q.tmr_en[`IPE_T_UF0]}; // RULE9
	assign lvl10    = s_q.prio_a[`IPE_A_TIMER10];
	assign lvl32    = s_q.prio_a[`IPE_A_TIMER32];
	assign tmr_lvl  = {lvl32, lvl32, lvl10, lvl10}; // RULE2 RULE3

	ipe_gate #(
		.N(8)
	) u_port_gate (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.req      (port_req),
		.en       (s_q.port_en),
		.level    ({8{s_q.prio_a[`IPE_A_PORT]}}), // RULE4
		.irq      (port_irq),
		.irq_level(port_irq_level)
	);

	// Sources 0-3 are compare match, 4-7 are underflow, both of timers 0-3.
	ipe_gate #(
		.N(8)
	) u_timer_gate (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.req      ({timer_underflow_req, timer_match_req}),
		.en       ({uf_en, match_en}),
		.level    ({tmr_lvl, tmr_lvl}),
		.irq      ({timer_underflow_irq, timer_match_irq}),
		.irq_level(timer_irq_level)
	);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence wr_commit(ipe_pkg::ipe_sel_e sel);
		wr_fire && s_q.wsel == sel && s_q.wstrb0;
	endsequence

	sequence wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence

	prio_a_write_a: // RULE1
	assert property (wr_commit(ipe_pkg::IPE_SEL_PRIO_A) |=>
		serial0_level == $past(s_q.wdata[7:6]) && port_level == $past(s_q.wdata[1:0]))
	else $error("Serial 0 or port priority did not take the written value.");

	timer10_shared_a: // RULE2
	assert property (timer_irq_level[1:0] == $past(timer10_level) &&
		timer_irq_level[3:2] == $past(timer10_level) &&
		timer_irq_level[9:8] == $past(timer10_level))
	else $error("Timer 0 or 1 request carries the wrong priority level.");

	reset_clear_a: // RULE3
	assert property ($rose(aresetn) |-> s_q.prio_a == `IPE_RST_REG &&
		s_q.prio_b == `IPE_RST_REG && s_q.tmr_en == `IPE_RST_REG &&
		s_q.port_en == `IPE_RST_REG)
	else $error("Registers not cleared by reset.");

	port_gate_a: // RULE4
	assert property (port_irq == $past(port_req & s_q.port_en &
		{8{port_level != `IPE_LEVEL_NONE}}) &&
		port_irq_level[15:14] == $past(port_level))
	else $error("Port request gating or level is wrong.");

	prio_b_write_a: // RULE5
	assert property (wr_commit(ipe_pkg::IPE_SEL_PRIO_B) |=>
		timer54_level == $past(s_q.wdata[7:6]) && timer76_level == $past(s_q.wdata[5:4]))
	else $error("Timer 5-4 or 7-6 priority did not take the written value.");

	clock_write_a: // RULE6
	assert property (wr_commit(ipe_pkg::IPE_SEL_PRIO_B) ##1 !wr_fire |=>
		clock_timer_level == $past(s_q.wdata[3:2], 2))
	else $error("Clock timer priority did not hold the written value.");

	serial1_write_a: // RULE7
	assert property (wr_commit(ipe_pkg::IPE_SEL_PRIO_B) |=>
		serial1_level == $past(s_q.wdata[1:0]))
	else $error("Serial 1 priority did not take the written value.");

	match_gate_a: // RULE8
	assert property (timer_match_irq == $past(timer_match_req & match_en &
		{lvl32 != `IPE_LEVEL_NONE, lvl32 != `IPE_LEVEL_NONE,
		lvl10 != `IPE_LEVEL_NONE, lvl10 != `IPE_LEVEL_NONE}))
	else $error("Compare match gating is wrong.");

	uf_gate_a: // RULE9
	assert property (timer_underflow_irq == $past(timer_underflow_req & uf_en &
		{lvl32 != `IPE_LEVEL_NONE, lvl32 != `IPE_LEVEL_NONE,
		lvl10 != `IPE_LEVEL_NONE, lvl10 != `IPE_LEVEL_NONE}))
	else $error("Underflow gating is wrong.");

	level0_block_a: // RULE10
	assert property (timer10_level == `IPE_LEVEL_NONE |=>
		timer_match_irq[1:0] == 2'h0 && timer_underflow_irq[1:0] == 2'h0)
	else $error("A level 0 timer request was forwarded.");

	level2_code_a: // RULE11
	assert property (port_level == 2'h2 && port_req[0] && s_q.port_en[0] |=>
		port_irq[0] && port_irq_level[1:0] == 2'h2)
	else $error("Code 10 did not forward as level 2.");

	// Address and data are held one cycle before the commit raises the response.
	write_resp_a:
	assert property (wr_taken |=> !awready && !wready ##1 bvalid && !awready && !wready)
	else $error("Write response not given two cycles after the write was taken.");

	bvalid_hold_a:
	assert property (bvalid && !bready |=> bvalid && $stable(bresp))
	else $error("Write response dropped before it was accepted.");

	read_resp_a:
	assert property (arvalid && arready |=> rvalid && !arready)
	else $error("Read data not given one cycle after the address was taken.");

endmodule : ipe_regs

/* File: test/ipe_cpu_model.sv */
`timescale 1ns/1ns
// Arbitrating core: reports the highest level among the requests it sees.
module ipe_cpu_model (
	input  wire logic        aclk,
	input  wire logic [7:0]  port_irq,
	input  wire logic [15:0] port_irq_level,
	input  wire logic [3:0]  timer_match_irq,
	input  wire logic [3:0]  timer_underflow_irq,
	input  wire logic [15:0] timer_irq_level,
	output logic      [1:0]  accept_level
);
	logic [15:0] req;
	logic [1:0]  max_d;
	assign req = {timer_underflow_irq, timer_match_irq, port_irq};
	always_comb
	begin
		max_d = 2'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (req[i] && port_irq_level[2*i+:2] > max_d)
				max_d = port_irq_level[2*i+:2];
			if (req[8+i] && timer_irq_level[2*i+:2] > max_d)
				max_d = timer_irq_level[2*i+:2];
		end
	end
	always_ff @(posedge aclk)
	begin
		accept_level <= max_d;
	end
endmodule : ipe_cpu_model

/* File: test/ipe_regs_bench.sv */
`timescale 1ns/1ns
`include "ipe_defs.svh"
module ipe_regs_bench;
	localparam logic [17:0] A_PA = {`IPE_IDX_PRIO_A, 2'h0};
	localparam logic [17:0] A_PB = {`IPE_IDX_PRIO_B, 2'h0};
	localparam logic [17:0] A_PE = {`IPE_IDX_PORT_EN, 2'h0};
	localparam logic [17:0] A_TE = {`IPE_IDX_TMR_EN, 2'h0};
	localparam logic [17:0] A_UN = {16'hFF12, 2'h0};
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, mreq, ureq, mirq, uirq;
	logic [1:0] bresp, rresp, l_s0, l_s1, l_t10, l_t32, l_t54, l_t76, l_ct, l_p, acc;
	logic [7:0] preq, pirq;
	logic [15:0] pil, til;
	int n_errors, checked;
	logic [17:0] ra[5] = '{A_PA, A_PB, A_PE, A_TE, A_UN};
	logic [7:0] rd[5] = '{8'hE4, 8'h1B, 8'hA5, 8'h8B, 8'h77};
	logic [7:0] re[5] = '{8'hE4, 8'h1B, 8'hA5, 8'h8B, 8'h00};
	logic [1:0] rr[5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
	logic [1:0] r;
	logic [31:0] v;

	ipe_regs ipe_regs_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.port_req(preq), .timer_match_req(mreq), .timer_underflow_req(ureq),
		.serial0_level(l_s0), .serial1_level(l_s1), .timer10_level(l_t10),
		.timer32_level(l_t32), .timer54_level(l_t54), .timer76_level(l_t76),
		.clock_timer_level(l_ct), .port_level(l_p), .port_irq(pirq),
		.port_irq_level(pil), .timer_match_irq(mirq), .timer_underflow_irq(uirq),
		.timer_irq_level(til));
	ipe_cpu_model ipe_cpu_model_inst (.aclk(aclk), .port_irq(pirq),
		.port_irq_level(pil), .timer_match_irq(mirq), .timer_underflow_irq(uirq),
		.timer_irq_level(til), .accept_level(acc));

	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task finish_test;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	// Master holds each channel until its own handshake edge.
	task wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] resp);
		logic aw, w, b;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int t = 0; t < 50; t++)
		begin
			@(negedge aclk);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
			if (b)
			begin
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task rd_reg(input logic [17:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ar, rv;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int t = 0; t < 50; t++)
		begin
			@(negedge aclk);
			ar = arvalid & arready;
			rv = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar)
				arvalid <= 1'b0;
			if (rv)
			begin
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd_reg

	task do_reset;
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, preq, mreq, ureq} = '0;
		wstrb = 4'h1;
		do_reset();
		for (int i = 0; i < 5; i++)
		begin
			wr(ra[i], rd[i], r);
			chk("bresp", r, rr[i]);
			rd_reg(ra[i], v, r);
			chk("rdata", v, re[i]);
			chk("rresp", r, rr[i]);
		end
		@(negedge aclk);
		chk("serial0", l_s0, 3);
		chk("timer10", l_t10, 2);
		chk("timer32", l_t32, 1);
		chk("port", l_p, 0);
		chk("timer54", l_t54, 0);
		chk("timer76", l_t76, 1);
		chk("clock", l_ct, 2);
		chk("serial1", l_s1, 3);
		$display("table done");
		@(posedge aclk);
		preq <= 8'hFF;
		mreq <= 4'hF;
		ureq <= 4'hF;
		repeat (2) @(negedge aclk);
		chk("port_irq lvl0", pirq, 8'h00);
		chk("match_irq", mirq, 4'b1011);
		chk("uf_irq", uirq, 4'b0001);
		chk("timer_lvl", til, 16'h5A5A);
		@(posedge aclk);
		wr(A_PA, 8'hE6, r);
		repeat (2) @(negedge aclk);
		chk("port_irq", pirq, 8'hA5);
		chk("port_lvl", pil, 16'hAAAA);
		chk("accept", acc, 2);
		@(posedge aclk);
		wstrb <= 4'h0;
		wr(A_PB, 8'hFF, r);
		chk("nostrb resp", r, 2'h0);
		rd_reg(A_PB, v, r);
		chk("nostrb data", v, 32'h1B);
		wstrb <= 4'h1;
		$display("gating done");
		do_reset();
		for (int i = 0; i < 4; i++)
		begin
			rd_reg(ra[i], v, r);
			chk("reset val", v, 32'h0);
			@(posedge aclk);
		end
		@(negedge aclk);
		chk("reset irq", pirq, 8'h00);
		$display("reset done");
		finish_test();
	end

	initial
	begin
		repeat (5000) @(posedge aclk);
		n_errors++;
		finish_test();
	end
endmodule : ipe_regs_bench
